// ===== hdl/timer2_control_unit.sv
// timer 2 control unit with an axi4-lite register slave
`default_nettype none
module timer2_control_unit (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // axi4-lite write
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and serial port
  input wire logic externalTriggerPin,
  input wire logic timer1Overflow,
  output logic rxBaudTick,
  output logic txBaudTick,
  output logic irq
);
  // ==========================================================
  // input synchroniser and tick generation
  logic trigMeta_r;
  logic trigSync_r;
  logic trigSamp_r;
  logic tick;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic down_count_enable_r;
  logic down_count_enable_nxt;
  logic [7:0] ckcfg_r;
  logic [7:0] ckcfg_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] cap_r;
  logic [15:0] cap_nxt;
  logic [1:0] istat_r;
  logic [1:0] istat_nxt;
  logic [1:0] imask_r;
  logic [1:0] imask_nxt;

  tick_divider #(.W(4)) u_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .divisor(ckcfg_r[timer2_pkg::DIVSEL_BIT] ? timer2_pkg::DIV_SLOW : timer2_pkg::DIV_FAST),
    .tick(tick)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trigMeta_r <= 1'b1;
      trigSync_r <= 1'b1;
      trigSamp_r <= 1'b1;
    end else begin
      trigMeta_r <= externalTriggerPin;
      trigSync_r <= trigMeta_r;
      if (tick) begin
        trigSamp_r <= trigSync_r;
      end
    end
  end

  // one detection per tick window: high sample then low sample
  logic trigFall;
  assign trigFall = tick && trigSamp_r && !trigSync_r;

  // ==========================================================
  // counter datapath
  logic baudMode;
  logic captureMode;
  logic countEn;
  logic downMode;
  logic overflow;
  logic underMatch;
  logic extAction;
  assign baudMode = ctrl_r[timer2_pkg::RXB_BIT] | ctrl_r[timer2_pkg::TXB_BIT];
  assign captureMode = ctrl_r[timer2_pkg::CAP_BIT] & !baudMode;
  assign countEn = ctrl_r[timer2_pkg::RUN_BIT] && tick &&
    (ctrl_r[timer2_pkg::SRC_BIT] ? trigFall : 1'b1);
  assign downMode = down_count_enable_r && !captureMode && !trigSync_r;
  assign overflow = countEn && !downMode && (cnt_r == 16'hffff);
  assign underMatch = countEn && downMode && (cnt_r == cap_r);
  assign extAction = trigFall && ctrl_r[timer2_pkg::EXEN_BIT] && !baudMode;

  // ==========================================================
  // register bus
  logic awHeld_r;
  logic awHeld_nxt;
  logic wHeld_r;
  logic wHeld_nxt;
  logic [7:0] awAddr_r;
  logic [7:0] awAddr_nxt;
  logic [31:0] wData_r;
  logic [31:0] wData_nxt;
  logic [3:0] wStrb_r;
  logic [3:0] wStrb_nxt;
  logic bValid_r;
  logic bValid_nxt;
  logic [1:0] bResp_r;
  logic [1:0] bResp_nxt;
  logic rValid_r;
  logic rValid_nxt;
  logic [31:0] rData_r;
  logic [31:0] rData_nxt;
  logic [1:0] rResp_r;
  logic [1:0] rResp_nxt;
  logic doWrite;
  logic doRead;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == timer2_pkg::CTRL_OFS) || (a == timer2_pkg::MODE_OFS) ||
      (a == timer2_pkg::CAPL_OFS) || (a == timer2_pkg::CAPH_OFS) ||
      (a == timer2_pkg::CNTL_OFS) || (a == timer2_pkg::CNTH_OFS) ||
      (a == timer2_pkg::CKCFG_OFS) || (a == timer2_pkg::ISTAT_OFS) ||
      (a == timer2_pkg::IMASK_OFS);
  endfunction

  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign s_axi_arready = !rValid_r;
  assign doRead = s_axi_arvalid && !rValid_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  logic wrByte;
  assign wrByte = doWrite && wStrb_r[0];

  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt = wHeld_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bValid_nxt = bValid_r;
    bResp_nxt = bResp_r;
    rValid_nxt = rValid_r;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt = mapped(awAddr_r) ? timer2_pkg::RESP_OKAY : timer2_pkg::RESP_SLVERR;
    end else if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    if (doRead) begin
      rValid_nxt = 1'b1;
      rResp_nxt = mapped(s_axi_araddr[9:2]) ?
        timer2_pkg::RESP_OKAY : timer2_pkg::RESP_SLVERR;
      unique case (s_axi_araddr[9:2])
        timer2_pkg::CTRL_OFS: rData_nxt = {24'h000000, ctrl_r};
        timer2_pkg::MODE_OFS: rData_nxt = {31'h00000000, down_count_enable_r};
        timer2_pkg::CAPL_OFS: rData_nxt = {24'h000000, cap_r[7:0]};
        timer2_pkg::CAPH_OFS: rData_nxt = {24'h000000, cap_r[15:8]};
        timer2_pkg::CNTL_OFS: rData_nxt = {24'h000000, cnt_r[7:0]};
        timer2_pkg::CNTH_OFS: rData_nxt = {24'h000000, cnt_r[15:8]};
        timer2_pkg::CKCFG_OFS: rData_nxt = {24'h000000, ckcfg_r};
        timer2_pkg::ISTAT_OFS: rData_nxt = {30'h00000000, istat_r};
        timer2_pkg::IMASK_OFS: rData_nxt = {30'h00000000, imask_r};
        default: rData_nxt = 32'h00000000;
      endcase
    end else if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= 2'h0;
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= 2'h0;
    end else begin
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bValid_r <= bValid_nxt;
      bResp_r <= bResp_nxt;
      rValid_r <= rValid_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
    end
  end

  // ==========================================================
  // timer state
  logic setOvf;
  logic setExt;
  logic istatRead;
  logic cntWr;
  assign setOvf = (overflow || underMatch) && !baudMode;
  assign setExt = extAction && !down_count_enable_r;
  assign istatRead = doRead && (s_axi_araddr[9:2] == timer2_pkg::ISTAT_OFS);
  assign cntWr = wrByte &&
    (awAddr_r == timer2_pkg::CNTL_OFS || awAddr_r == timer2_pkg::CNTH_OFS);

  always_comb begin
    ctrl_nxt = ctrl_r;
    down_count_enable_nxt = down_count_enable_r;
    ckcfg_nxt = ckcfg_r;
    cnt_nxt = cnt_r;
    cap_nxt = cap_r;
    imask_nxt = imask_r;
    istat_nxt = istatRead ? 2'b00 : istat_r;
    // software writes first so that hardware sets win in the same cycle
    if (wrByte) begin
      unique case (awAddr_r)
        timer2_pkg::CTRL_OFS: ctrl_nxt = wData_r[7:0];
        timer2_pkg::MODE_OFS: down_count_enable_nxt = wData_r[timer2_pkg::DOWN_COUNT_ENABLE_BIT];
        timer2_pkg::CAPL_OFS: cap_nxt[7:0] = wData_r[7:0];
        timer2_pkg::CAPH_OFS: cap_nxt[15:8] = wData_r[7:0];
        timer2_pkg::CNTL_OFS: cnt_nxt[7:0] = wData_r[7:0];
        timer2_pkg::CNTH_OFS: cnt_nxt[15:8] = wData_r[7:0];
        timer2_pkg::CKCFG_OFS: ckcfg_nxt = wData_r[7:0];
        timer2_pkg::IMASK_OFS: imask_nxt = wData_r[1:0];
        default: ;
      endcase
    end
    if (countEn && !cntWr) begin
      if (downMode) begin
        cnt_nxt = (cnt_r == cap_r) ? 16'hffff : cnt_r - 16'h0001;
      end else if (overflow && !captureMode) begin
        cnt_nxt = cap_r;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
    if (extAction) begin
      if (captureMode) begin
        cap_nxt = cnt_r;
      end else if (!downMode) begin
        cnt_nxt = cap_r;
      end
    end
    if (setOvf) begin
      ctrl_nxt[timer2_pkg::OVF_BIT] = 1'b1;
      istat_nxt[timer2_pkg::IRQ_OVF] = 1'b1;
    end
    if (setExt) begin
      ctrl_nxt[timer2_pkg::EXT_BIT] = 1'b1;
      istat_nxt[timer2_pkg::IRQ_EXT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r <= timer2_pkg::CTRL_RST;
      down_count_enable_r <= 1'b0;
      ckcfg_r <= timer2_pkg::CKCFG_RST;
      cnt_r <= timer2_pkg::CNT_RST;
      cap_r <= timer2_pkg::CNT_RST;
      istat_r <= 2'b00;
      imask_r <= 2'b00;
      rxBaudTick <= 1'b0;
      txBaudTick <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      down_count_enable_r <= down_count_enable_nxt;
      ckcfg_r <= ckcfg_nxt;
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      rxBaudTick <= ctrl_r[timer2_pkg::RXB_BIT] ? overflow : timer1Overflow;
      txBaudTick <= ctrl_r[timer2_pkg::TXB_BIT] ? overflow : timer1Overflow;
    end
  end

  // flag bits in control also request the interrupt while set
  assign irq = |(imask_r & (istat_r |
    {ctrl_r[timer2_pkg::EXT_BIT], ctrl_r[timer2_pkg::OVF_BIT]}));

  // ==========================================================
  // checks
  a_ovf_sets_flag: assert property (@(posedge ref_clk) disable iff (srst)
    setOvf |=> ctrl_r[timer2_pkg::OVF_BIT]) else $error("overflow flag not set");
  a_ovf_no_hw_clear: assert property (@(posedge ref_clk) disable iff (srst)
    ctrl_r[timer2_pkg::OVF_BIT] && !wrByte |=> ctrl_r[timer2_pkg::OVF_BIT])
    else $error("overflow flag cleared by hardware");
  a_ext_sets_flag: assert property (@(posedge ref_clk) disable iff (srst)
    setExt |=> ctrl_r[timer2_pkg::EXT_BIT] && istat_r[timer2_pkg::IRQ_EXT])
    else $error("external flag not set");
  a_ext_irq: assert property (@(posedge ref_clk) disable iff (srst)
    ctrl_r[timer2_pkg::EXT_BIT] && imask_r[timer2_pkg::IRQ_EXT] |-> irq)
    else $error("external flag without interrupt");
  a_rx_base: assert property (@(posedge ref_clk) disable iff (srst)
    ctrl_r[timer2_pkg::RXB_BIT] && overflow && !wrByte |=> rxBaudTick)
    else $error("receive base missed overflow");
  a_tx_base: assert property (@(posedge ref_clk) disable iff (srst)
    !ctrl_r[timer2_pkg::TXB_BIT] && !wrByte |=> txBaudTick == $past(timer1Overflow))
    else $error("transmit base not timer 1");
  a_no_ext_off: assert property (@(posedge ref_clk) disable iff (srst)
    !ctrl_r[timer2_pkg::EXEN_BIT] |-> !extAction) else $error("edge acted while disabled");
  a_hold_stop: assert property (@(posedge ref_clk) disable iff (srst)
    !ctrl_r[timer2_pkg::RUN_BIT] && !wrByte && !extAction |=> $stable(cnt_r))
    else $error("stopped counter moved");
  a_capture: assert property (@(posedge ref_clk) disable iff (srst)
    extAction && captureMode && !wrByte |=> cap_r == $past(cnt_r))
    else $error("capture missed");
  a_reload: assert property (@(posedge ref_clk) disable iff (srst)
    overflow && !captureMode && !wrByte |=> cnt_r == $past(cap_r))
    else $error("reload missed");
endmodule
`default_nettype wire

// ===== hdl/timer2_pkg.sv
// constants for the general-purpose 16-bit timer control unit
// Contract
// - with both baud selects low, overflow or down-count match sets overflow flag bit 7.
// - software may set or clear overflow flag; hardware never clears it.
// - capture/reload mode, down-count off, external enable on: pin fall sets bit 6.
// - software may set external flag; it requests interrupt until software clears it.
// - bit 5 makes timer overflow the receive baud time base; else timer 1.
// - bit 4 makes timer overflow the transmit baud time base; else timer 1.
// - outside baud mode, bit 3 lets pin falling edge capture or reload.
// - bit 2 runs the counter; at 0 the counter holds its value except for pin-edge reloads.
// - bit 1 low counts divided ticks; high counts pin falling edges.
// - bit 0 low reloads on overflow or pin edge; high captures on pin edge.
// - either baud select forces auto-reload, ignoring capture/reload select.
// - capture pair latches counter bytes; in reload mode it supplies reload value.
// - down-count enable lets the trigger pin choose count direction in auto-reload.
`default_nettype none
package timer2_pkg;
  // register indices; the bus byte address is four times the index
  localparam logic [7:0] CTRL_OFS = 8'hc8;
  localparam logic [7:0] MODE_OFS = 8'hc9;
  localparam logic [7:0] CAPL_OFS = 8'hca;
  localparam logic [7:0] CAPH_OFS = 8'hcb;
  localparam logic [7:0] CNTL_OFS = 8'hcc;
  localparam logic [7:0] CNTH_OFS = 8'hcd;
  localparam logic [7:0] CKCFG_OFS = 8'hdf;
  localparam logic [7:0] ISTAT_OFS = 8'hd4;
  localparam logic [7:0] IMASK_OFS = 8'hd8;
  // control, mode and clock-config field positions
  localparam int OVF_BIT = 7;
  localparam int EXT_BIT = 6;
  localparam int RXB_BIT = 5;
  localparam int TXB_BIT = 4;
  localparam int EXEN_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int SRC_BIT = 1;
  localparam int CAP_BIT = 0;
  localparam int DOWN_COUNT_ENABLE_BIT = 0;
  localparam int DIVSEL_BIT = 5;
  // interrupt status bits
  localparam int IRQ_OVF = 0;
  localparam int IRQ_EXT = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CKCFG_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // tick dividers in clocks
  localparam logic [3:0] DIV_FAST = 4'h6;
  localparam logic [3:0] DIV_SLOW = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== hdl/tick_divider.sv
// programmable divider giving a one-cycle tick enable
`default_nettype none
module tick_divider #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // control
  input wire logic [W-1:0] divisor,
  output logic tick
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    if (cnt_r >= divisor - W'(1)) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick = (cnt_r == '0);
endmodule
`default_nettype wire

// ===== dv/baud_partner.sv
// far-side model: trigger pin, timer 1 overflow source and serial baud tick tallies
`default_nettype none
module baud_partner (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // bench control
  input wire logic pinLevel,
  input wire logic t1Run,
  // design side
  output logic externalTriggerPin,
  output logic timer1Overflow,
  input wire logic rxBaudTick,
  input wire logic txBaudTick,
  // tallies
  output int rxSeen,
  output int txSeen,
  output int t1Sent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div;
  // the pin follows pinLevel directly, so it only ever shows the level the bench asks for
  assign externalTriggerPin = pinLevel;
  // timer 1 overflows every eight clocks while enabled
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div <= 3'h0;
      timer1Overflow <= 1'b0;
      rxSeen <= 0;
      txSeen <= 0;
      t1Sent <= 0;
    end else begin
      div <= t1Run ? div + 3'h1 : 3'h0;
      timer1Overflow <= t1Run && (div == 3'h7);
      rxSeen <= rxSeen + int'(rxBaudTick);
      txSeen <= txSeen + int'(txBaudTick);
      t1Sent <= t1Sent + int'(timer1Overflow);
    end
  end
endmodule
`default_nettype wire

// ===== dv/timer2_control_unit_tb_top.sv
// self-checking bench for the timer 2 control unit
`default_nettype none
module timer2_control_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] awAddr = 10'h000;
  logic [9:0] arAddr = 10'h000;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic pin = 1'b1, t1Run = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, trig, t1Ovf, rxTick, txTick, irq;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  int rxSeen, txSeen, t1Sent, r0, x0, s0, n;
  int nFail = 0;
  int checkCount = 0;
  int seed = 55;
  int regModel [256];

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  timer2_control_unit u_dut (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .externalTriggerPin(trig), .timer1Overflow(t1Ovf), .rxBaudTick(rxTick),
    .txBaudTick(txTick), .irq(irq));

  baud_partner u_partner (.ref_clk(ref_clk), .srst(srst), .pinLevel(pin), .t1Run(t1Run),
    .externalTriggerPin(trig), .timer1Overflow(t1Ovf), .rxBaudTick(rxTick),
    .txBaudTick(txTick), .rxSeen(rxSeen), .txSeen(txSeen), .t1Sent(t1Sent));

  // ==========================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nFail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrapUp();
    $display("comparisons=%0d mismatches=%0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bound(input int k);
    if (k > 600) begin
      nFail++;
      wrapUp();
    end
  endtask

  // ==========================================
  // register bus master; each task ends one edge after the answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = timer2_pkg::RESP_OKAY);
    int k;
    logic done;
    k = 0;
    done = 1'b0;
    regModel[a] = d;
    awAddr <= {a, 2'b00};
    wData <= {24'h000000, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      k++;
      bound(k);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid) begin
        done = 1'b1;
        bReady <= 1'b0;
        chk(bResp, er);
      end
    end
    @(posedge ref_clk);
  endtask

  task automatic rdReg(input logic [7:0] a, input logic [7:0] e,
                       input logic [1:0] er = timer2_pkg::RESP_OKAY);
    int k;
    logic done;
    k = 0;
    done = 1'b0;
    arAddr <= {a, 2'b00};
    arValid <= 1'b1;
    rReady <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      k++;
      bound(k);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid) begin
        done = 1'b1;
        rReady <= 1'b0;
        chk(rData, {24'h000000, e});
        chk(rResp, er);
      end
    end
    @(posedge ref_clk);
  endtask

  // one falling then rising edge, each level held across many ticks
  task automatic fall();
    pin <= 1'b0;
    repeat (80) @(posedge ref_clk);
    pin <= 1'b1;
    repeat (80) @(posedge ref_clk);
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rdReg(timer2_pkg::CTRL_OFS, timer2_pkg::CTRL_RST);
    rdReg(timer2_pkg::CKCFG_OFS, timer2_pkg::CKCFG_RST);
    rdReg(8'hc4, 8'h00, timer2_pkg::RESP_SLVERR);
    wr(8'hc4, 8'h55, timer2_pkg::RESP_SLVERR);
    wr(timer2_pkg::IMASK_OFS, 8'h03);
    rdReg(timer2_pkg::IMASK_OFS, 8'(regModel[timer2_pkg::IMASK_OFS]));
    n = $random(seed);
    wr(timer2_pkg::MODE_OFS, 8'h00);
    wr(timer2_pkg::CAPL_OFS, 8'(n));
    rdReg(timer2_pkg::CAPL_OFS, 8'(regModel[timer2_pkg::CAPL_OFS]));
    // overflow with the slow tick, reload from 0xfff0
    wr(timer2_pkg::CKCFG_OFS, 8'h20);
    wr(timer2_pkg::CAPL_OFS, 8'hf0);
    wr(timer2_pkg::CAPH_OFS, 8'hff);
    wr(timer2_pkg::CNTL_OFS, 8'hf0);
    wr(timer2_pkg::CNTH_OFS, 8'hff);
    wr(timer2_pkg::CTRL_OFS, 8'h04);
    n = 0;
    while (!irq) begin
      @(posedge ref_clk);
      n++;
      bound(n);
    end
    rdReg(timer2_pkg::CTRL_OFS, 8'h84);
    wr(timer2_pkg::CTRL_OFS, 8'h80);
    rdReg(timer2_pkg::CNTH_OFS, 8'hff);
    rdReg(timer2_pkg::CTRL_OFS, 8'h80);
    rdReg(timer2_pkg::ISTAT_OFS, 8'h01);
    rdReg(timer2_pkg::ISTAT_OFS, 8'h00);
    wr(timer2_pkg::CTRL_OFS, 8'h00);
    chk(irq, 1'b0);
    // baud modes; capture select set to show it is ignored
    for (int k = 0; k < 2; k++) begin
      wr(timer2_pkg::CTRL_OFS, k ? 8'h25 : 8'h15);
      r0 = rxSeen;
      x0 = txSeen;
      s0 = t1Sent;
      t1Run <= 1'b1;
      repeat (600) @(posedge ref_clk);
      t1Run <= 1'b0;
      repeat (5) @(posedge ref_clk);
      chk(k ? txSeen - x0 : rxSeen - r0, t1Sent - s0);
      chk((k ? rxSeen - r0 : txSeen - x0) > 0, 1);
      rdReg(timer2_pkg::CTRL_OFS, k ? 8'h25 : 8'h15);
      rdReg(timer2_pkg::CNTH_OFS, 8'hff);
    end
    wr(timer2_pkg::CKCFG_OFS, 8'h00);
    // external edge capture
    wr(timer2_pkg::CAPH_OFS, 8'h00);
    wr(timer2_pkg::CNTL_OFS, 8'h00);
    wr(timer2_pkg::CNTH_OFS, 8'h12);
    wr(timer2_pkg::CTRL_OFS, 8'h0d);
    fall();
    rdReg(timer2_pkg::CTRL_OFS, 8'h4d);
    rdReg(timer2_pkg::ISTAT_OFS, 8'h02);
    rdReg(timer2_pkg::CAPH_OFS, 8'h12);
    wr(timer2_pkg::CNTH_OFS, 8'h34);
    wr(timer2_pkg::CTRL_OFS, 8'h05);
    fall();
    rdReg(timer2_pkg::CTRL_OFS, 8'h05);
    rdReg(timer2_pkg::CAPH_OFS, 8'h12);
    wr(timer2_pkg::CTRL_OFS, 8'h40);
    chk(irq, 1'b1);
    rdReg(timer2_pkg::CTRL_OFS, 8'h40);
    // count a random number of pin falls, then stop and hold
    n = ($unsigned($random(seed)) % 8) + 1;
    wr(timer2_pkg::CTRL_OFS, 8'h00);
    wr(timer2_pkg::CNTL_OFS, 8'h00);
    wr(timer2_pkg::CNTH_OFS, 8'h00);
    wr(timer2_pkg::CTRL_OFS, 8'h06);
    repeat (n) fall();
    rdReg(timer2_pkg::CNTL_OFS, 8'(n));
    wr(timer2_pkg::CTRL_OFS, 8'h02);
    fall();
    fall();
    rdReg(timer2_pkg::CNTL_OFS, 8'(n));
    rdReg(timer2_pkg::CNTH_OFS, 8'h00);
    // down count with the pin held low: all ones reload at the match
    pin <= 1'b0;
    wr(timer2_pkg::MODE_OFS, 8'h01);
    rdReg(timer2_pkg::MODE_OFS, 8'h01);
    wr(timer2_pkg::CAPL_OFS, 8'h00);
    wr(timer2_pkg::CAPH_OFS, 8'h00);
    wr(timer2_pkg::CNTL_OFS, 8'h03);
    wr(timer2_pkg::CTRL_OFS, 8'h04);
    n = 0;
    while (!irq) begin
      @(posedge ref_clk);
      n++;
      bound(n);
    end
    rdReg(timer2_pkg::CTRL_OFS, 8'h84);
    wr(timer2_pkg::CTRL_OFS, 8'h00);
    rdReg(timer2_pkg::CNTH_OFS, 8'hff);
    rdReg(timer2_pkg::ISTAT_OFS, 8'h01);
    pin <= 1'b1;
    wrapUp();
  end
endmodule
`default_nettype wire
